// ==== design/tlc_pkg.sv ====
// Shared constants for the temperature loop command handshake.
// Assumes 16-bit output and input words exchanged on one clock.
package tlc_pkg;
  // Command word layout: [15:12] tag, [11:8] write item/op, [7:4]
  // monitor item, [3:0] loop number
  localparam logic [3:0]  CMD_TAG     = 4'hc;
  localparam int          TAG_MSB     = 15;
  localparam int          WR_MSB      = 11;
  localparam int          MON_MSB     = 7;
  localparam int          LOOP_MSB    = 3;
  localparam logic [3:0]  OP_NIB      = 4'hc;
  // Operation codes in [7:4] when [11:8] is OP_NIB
  localparam logic [3:0]  OP_STOP     = 4'hc;
  localparam logic [3:0]  OP_RUN      = 4'hd;
  localparam logic [3:0]  OP_TUNE     = 4'he;
  localparam logic [3:0]  OP_MANUAL   = 4'hb;
  localparam logic [3:0]  OP_AUTO     = 4'ha;
  localparam logic [3:0]  LOOP_ALL    = 4'ha;
  // Item codes
  localparam logic [3:0]  WR_SHIFT    = 4'h6;
  localparam logic [3:0]  WR_NONE     = 4'h7;
  localparam logic [3:0]  WR_MANUAL   = 4'h8;
  localparam logic [3:0]  WR_ALARM    = 4'ha;
  localparam logic [3:0]  MON_PV      = 4'h7;
  localparam logic [3:0]  MON_MV      = 4'h8;
  localparam logic [3:0]  MON_STAT    = 4'h9;
  localparam logic [3:0]  MON_ALARM   = 4'ha;
  localparam logic [3:0]  MON_CURR    = 4'hb;
  // Answer codes and limits, currents in 0.1 A
  localparam logic [15:0] ERR_SETTING = 16'hee01;
  localparam logic [15:0] CURR_ERR    = 16'he500;
  localparam logic [15:0] ALARM_OFF   = 16'h0000;
  localparam logic [15:0] ALARM_FORCE = 16'h01f4;
  localparam logic [15:0] CURR_LIMIT  = 16'h0226;
  localparam logic [15:0] MV_FULL     = 16'h03e8;
  localparam logic [9:0]  DUTY_LAST   = 10'h3e7;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;
  // Status word bit positions
  localparam int          ST_OUT      = 0;
  localparam int          ST_TUNE     = 1;
  localparam int          ST_SENSOR   = 2;
  localparam int          ST_ALARM    = 3;
  localparam int          ST_CT       = 4;
  localparam int          ST_STOP     = 5;
  localparam int          ST_MANUAL   = 6;
  // Parameter reset values, items 0..6 (index 0 lowest)
  localparam logic [6:0][15:0] PARAM_RST = {16'h0000, 16'h0014,
    16'h0008, 16'h0028, 16'h00f0, 16'h0190, 16'h0000};
endpackage : tlc_pkg

// ==== design/io_word_if.sv ====
// Output word (host to unit) and input word (unit to host).
// Both ends run on the same clock and reset.
`timescale 1ns/10ps
interface io_word_if (
  input wire logic clk
);
  logic [15:0] out_word;
  logic [15:0] in_word;
  modport host (input clk, output out_word, input in_word);
  modport dev  (input clk, input out_word, output in_word);
endinterface : io_word_if

// ==== design/hb_detect.sv ====
// Heater burnout alarm and current-sense error for one loop.
// Assumes current and setting are already on the clk domain.
`timescale 1ns/10ps
module hb_detect
  import tlc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] setting,
  input  wire logic [15:0] current,
  input  wire logic        ctl_on,
  output logic             alarm,
  output logic             ct_err
);
  typedef struct packed {
    logic alarm;
    logic ct_err;
  } hb_state_t;

  hb_state_t st_r;
  hb_state_t st_nxt;

  // Latched alarm, cleared only by a zero setting
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ct_err = (current >= CURR_LIMIT);
    if (setting == ALARM_OFF)
      st_nxt.alarm = 1'b0;
    else if (setting == ALARM_FORCE)
      st_nxt.alarm = 1'b1;
    else if (ctl_on && current < setting)
      st_nxt.alarm = 1'b1;
  end

  // State register; alarm sets while detecting, or on an ALARM_FORCE setting
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign alarm  = st_r.alarm;
  assign ct_err = st_r.ct_err;
endmodule : hb_detect

// ==== design/temp_loop_dev.sv ====
// Unit end: command interpreter and loop monitoring logic.
// Assumes the host drives out_word from a flop on the same clock;
// process value and heater current come from pins.
`timescale 1ns/10ps
module temp_loop_dev
  import tlc_pkg::*;
#(
  parameter int          LOOPS       = 4,
  parameter int          TUNE_CYCLES = 5000,
  parameter logic [15:0] RANGE_LO    = 16'hff38,
  parameter logic [15:0] RANGE_HI    = 16'h0514
)
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  io_word_if.dev                      io,
  input  wire logic [LOOPS-1:0][15:0] pv_raw,
  input  wire logic [LOOPS-1:0][15:0] curr_raw,
  output logic      [LOOPS-1:0]       ctl_out,
  output logic      [LOOPS-1:0]       burnout_alarm_out
);
  import tlc_pkg::*;

  typedef enum logic [1:0] {D_IDLE, D_DATA, D_MON, D_ERR} dstate_t;

  typedef struct packed {
    logic [LOOPS-1:0][15:0]      pv_s1;
    logic [LOOPS-1:0][15:0]      pv_s2;
    logic [LOOPS-1:0][15:0]      cur_s1;
    logic [LOOPS-1:0][15:0]      cur_s2;
    logic [15:0]                 last_out;
    logic [15:0]                 in_word;
    logic [15:0]                 cmd;
    dstate_t                     st;
    logic [LOOPS-1:0][6:0][15:0] prm;
    logic [LOOPS-1:0][15:0]      alarm_set;
    logic [LOOPS-1:0][15:0]      man_mv;
    logic [LOOPS-1:0][15:0]      auto_mv;
    logic [LOOPS-1:0][31:0]      tune_cnt;
    logic [LOOPS-1:0]            run;
    logic [LOOPS-1:0]            manual;
    logic [LOOPS-1:0]            tuning;
    logic [LOOPS-1:0]            ctl;
    logic [9:0]                  duty;
  } dev_state_t;

  dev_state_t q_r;
  dev_state_t q_nxt;

  logic [LOOPS-1:0][15:0] pv_ind;
  logic [LOOPS-1:0]       sensor_err;
  logic [LOOPS-1:0]       ct_err;

  // Per-loop shifted value, range check and alarm detector
  genvar g;
  generate
    for (g = 0; g < LOOPS; g++)
    begin : g_loop
      assign pv_ind[g] = q_r.pv_s2[g] + q_r.prm[g][WR_SHIFT];
      assign sensor_err[g] = $signed(pv_ind[g]) < $signed(RANGE_LO) ||
                             $signed(pv_ind[g]) > $signed(RANGE_HI);
      hb_detect u_hb (
        .clk     (clk),
        .sys_rst (sys_rst),
        .setting (q_r.alarm_set[g]),
        .current (q_r.cur_s2[g]),
        .ctl_on  (q_r.ctl[g]),
        .alarm   (burnout_alarm_out[g]),
        .ct_err  (ct_err[g])
      );
    end
  endgenerate

  // Next-state logic: loops, command decode, write and monitor
  always_comb
  begin
    logic [15:0] w;
    logic [3:0]  wi;
    logic [3:0]  mi;
    logic [3:0]  ln;
    int          li;
    w  = io.out_word;
    wi = w[WR_MSB -: 4];
    mi = w[MON_MSB -: 4];
    ln = w[LOOP_MSB -: 4];
    li = 0;
    q_nxt = q_r;
    q_nxt.pv_s1  = pv_raw;
    q_nxt.pv_s2  = q_r.pv_s1;
    q_nxt.cur_s1 = curr_raw;
    q_nxt.cur_s2 = q_r.cur_s1;
    q_nxt.duty = (q_r.duty == DUTY_LAST) ? 10'h000 : q_r.duty + 10'h001;
    // Loop control and self-tuning timer
    for (int l = 0; l < LOOPS; l++)
    begin
      if (q_r.run[l] && !sensor_err[l] &&
          $signed(pv_ind[l]) < $signed(q_r.prm[l][0]))
        q_nxt.auto_mv[l] = MV_FULL;
      else
        q_nxt.auto_mv[l] = WORD_ZERO;
      if (q_r.manual[l])
        q_nxt.ctl[l] = {6'h00, q_r.duty} < q_r.man_mv[l];
      else
        q_nxt.ctl[l] = q_r.auto_mv[l] != WORD_ZERO;
      if (q_r.tuning[l])
      begin
        if (q_r.tune_cnt[l] <= 32'd1)
        begin
          q_nxt.tuning[l] = 1'b0;
          if (w == {CMD_TAG, OP_NIB, OP_TUNE, 4'(l + 1)} ||
              w == {CMD_TAG, OP_NIB, OP_TUNE, LOOP_ALL})
          begin
            q_nxt.tuning[l]   = 1'b1;
            q_nxt.tune_cnt[l] = 32'(TUNE_CYCLES);
          end
        end
        else
          q_nxt.tune_cnt[l] = q_r.tune_cnt[l] - 32'd1;
      end
    end
    // New word from the host
    if (w != q_r.last_out)
    begin
      q_nxt.last_out = w;
      if (w[TAG_MSB -: 4] == CMD_TAG && wi == OP_NIB)
      begin
        // Operation command: acknowledge and apply
        q_nxt.in_word = w;
        q_nxt.st = D_IDLE;
        for (int l = 0; l < LOOPS; l++)
        begin
          if (ln == LOOP_ALL || ln == 4'(l + 1))
          begin
            case (mi)
              OP_STOP:   q_nxt.run[l] = 1'b0;
              OP_RUN:    q_nxt.run[l] = 1'b1;
              OP_AUTO:   q_nxt.manual[l] = 1'b0;
              OP_MANUAL:
              begin
                if (!q_r.manual[l])
                  q_nxt.man_mv[l] = q_r.auto_mv[l];
                q_nxt.manual[l] = 1'b1;
              end
              OP_TUNE:
              begin
                q_nxt.tuning[l]   = 1'b1;
                q_nxt.tune_cnt[l] = 32'(TUNE_CYCLES);
              end
              default: q_nxt.run[l] = q_r.run[l];
            endcase
          end
        end
      end
      else if (w[TAG_MSB -: 4] == CMD_TAG)
      begin
        // Allocation command: validate codes and loop
        if ((wi <= WR_MANUAL || wi == WR_ALARM) && mi <= MON_CURR &&
            ln >= 4'h1 && ln <= 4'(LOOPS))
        begin
          q_nxt.in_word = w;
          q_nxt.cmd = w;
          q_nxt.st = D_DATA;
        end
        else
        begin
          q_nxt.in_word = ERR_SETTING;
          q_nxt.st = D_ERR;
        end
      end
      else if (q_r.st == D_DATA || q_r.st == D_MON)
      begin
        // Write data, applied to the held command
        li = int'(q_r.cmd[LOOP_MSB -: 4]) - 1;
        q_nxt.st = D_MON;
        if (!q_r.tuning[li])
        begin
          case (q_r.cmd[WR_MSB -: 4])
            WR_NONE:   q_nxt.cmd = q_r.cmd;
            WR_MANUAL: q_nxt.man_mv[li] = w;
            WR_ALARM:  q_nxt.alarm_set[li] = w;
            default:   q_nxt.prm[li][q_r.cmd[WR_MSB-1 -: 3]] = w;
          endcase
        end
      end
    end
    else if (q_r.st == D_MON)
    begin
      // Monitor answer, refreshed every cycle
      li = int'(q_r.cmd[LOOP_MSB -: 4]) - 1;
      case (q_r.cmd[MON_MSB -: 4])
        MON_PV:    q_nxt.in_word = pv_ind[li];
        MON_MV:    q_nxt.in_word = q_r.manual[li] ? q_r.man_mv[li]
                                                  : q_r.auto_mv[li];
        MON_STAT:  q_nxt.in_word = {9'h000, !q_r.manual[li] ? 1'b0 : 1'b1,
                                    !q_r.run[li], ct_err[li],
                                    burnout_alarm_out[li], sensor_err[li],
                                    q_r.tuning[li], q_r.ctl[li]};
        MON_ALARM: q_nxt.in_word = q_r.alarm_set[li];
        MON_CURR:  q_nxt.in_word = ct_err[li] ? CURR_ERR
                                              : q_r.cur_s2[li];
        default:   q_nxt.in_word = q_r.prm[li][q_r.cmd[MON_MSB-1 -: 3]];
      endcase
    end
  end

  // State register; power-up stopped, auto, nothing pending
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q_r <= '0;
      for (int l = 0; l < LOOPS; l++)
        q_r.prm[l] <= PARAM_RST;
    end
    else
      q_r <= q_nxt;
  end

  assign io.in_word = q_r.in_word;
  assign ctl_out    = q_r.ctl;
endmodule : temp_loop_dev

// ==== design/temp_loop_host.sv ====
// Host end: posts a command, waits for its echo, posts data and
// returns the monitored answer. Same clock as the unit end.
`timescale 1ns/10ps
module temp_loop_host
  import tlc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  io_word_if.host          io,
  input  wire logic        req_valid,
  input  wire logic [15:0] req_cmd,
  input  wire logic [15:0] req_data,
  output logic             req_ready,
  output logic             done,
  output logic             err,
  output logic [15:0]      result
);
  import tlc_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_POST, H_CMD, H_DATA} hstate_t;

  typedef struct packed {
    hstate_t     st;
    logic [15:0] out_word;
    logic [15:0] data;
    logic        ready;
    logic        done;
    logic        err;
    logic [15:0] result;
  } host_state_t;

  host_state_t q_r;
  host_state_t q_nxt;

  // Handshake sequencer
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    case (q_r.st)
      H_IDLE:
      begin
        q_nxt.ready = 1'b1;
        if (req_valid && q_r.ready)
        begin
          q_nxt.out_word = req_cmd;
          q_nxt.data = (req_cmd[WR_MSB -: 4] == WR_NONE) ? WORD_ZERO
                                                         : req_data;
          q_nxt.ready = 1'b0;
          q_nxt.st = H_POST;
        end
      end
      H_POST:
      begin
        // Stale answer still stands; unit sees command this edge
        q_nxt.st = H_CMD;
      end
      H_CMD:
      begin
        if (io.in_word == ERR_SETTING)
        begin
          q_nxt.out_word = WORD_ZERO;
          q_nxt.err = 1'b1;
          q_nxt.result = io.in_word;
          q_nxt.done = 1'b1;
          q_nxt.st = H_IDLE;
        end
        else if (io.in_word == q_r.out_word)
        begin
          q_nxt.err = 1'b0;
          if (q_r.out_word[WR_MSB -: 4] == OP_NIB)
          begin
            q_nxt.out_word = WORD_ZERO;
            q_nxt.result = io.in_word;
            q_nxt.done = 1'b1;
            q_nxt.st = H_IDLE;
          end
          else
          begin
            q_nxt.out_word = q_r.data;
            q_nxt.result = q_r.out_word;
            q_nxt.st = H_DATA;
          end
        end
      end
      H_DATA:
      begin
        if (io.in_word != q_r.result)
        begin
          q_nxt.result = io.in_word;
          q_nxt.err = io.in_word == ERR_SETTING;
          q_nxt.done = 1'b1;
          q_nxt.st = H_IDLE;
        end
      end
      default: q_nxt.st = H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign io.out_word = q_r.out_word;
  assign req_ready   = q_r.ready;
  assign done        = q_r.done;
  assign err         = q_r.err;
  assign result      = q_r.result;
endmodule : temp_loop_host

// ==== dv/temp_loop_command_handshake_props.sv ====
// Checker for the output and input words between host and unit end.
// Assumes it sits beside the interface, on the shared clock and reset.
`timescale 1ns/10ps
module temp_loop_command_handshake_props #(
  parameter int LOOPS = 4
)
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [15:0] out_word,
  input wire logic [15:0] in_word
);
  // One clock domain for every property
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // New command word while the unit is not waiting for data
  sequence fresh_s;
    $changed(out_word) && out_word[15:12] == 4'hc &&
      $past(in_word) != $past(out_word);
  endsequence

  reset_clear_a: assert property (
    $fell(sys_rst) |-> in_word == 16'h0000 ##1 in_word == 16'h0000)
    else $error("input word not clear after reset");
  cmd_echo_a: assert property (
    fresh_s |=> in_word == $past(out_word) || in_word == 16'hee01)
    else $error("command not acknowledged in one cycle");
  bad_write_a: assert property (
    fresh_s ##0 (out_word[11:8] == 4'h9 || out_word[11:8] == 4'hb ||
      out_word[11:8] > 4'hc) |=> in_word == 16'hee01)
    else $error("forbidden write code not refused");
  bad_mon_a: assert property (
    fresh_s ##0 (out_word[11:8] != 4'hc && out_word[7:4] > 4'hb)
    |=> in_word == 16'hee01)
    else $error("unlisted monitor code not refused");
  bad_loop_a: assert property (
    fresh_s ##0 (out_word[11:8] != 4'hc && (out_word[3:0] == 4'h0 ||
      out_word[3:0] > LOOPS)) |=> in_word == 16'hee01)
    else $error("bad loop number not refused");
  op_echo_a: assert property (
    fresh_s ##0 (out_word[11:8] == 4'hc && out_word[7:4] >= 4'ha &&
      out_word[7:4] <= 4'he && out_word[3:0] == 4'h1)
    |=> in_word == $past(out_word))
    else $error("operation command not echoed");
  write_done_a: assert property (
    $changed(out_word) && $past(in_word) == $past(out_word) &&
      $past(out_word[15:12]) == 4'hc && $past(out_word[11:8]) != 4'hc
    |=> $stable(in_word) ##1 $changed(in_word))
    else $error("monitor value not two cycles after data");
  err_hold_a: assert property (
    in_word == 16'hee01 && out_word[15:12] != 4'hc
    |=> in_word == 16'hee01)
    else $error("error answer dropped without new command");
endmodule : temp_loop_command_handshake_props

// ==== dv/tb_temp_loop_command_handshake.sv ====
// Testbench joining host end and unit end across the word interface.
// Assumes a 25 MHz clock and a short self-tune stand-in count.
`timescale 1ns/10ps
module tb_temp_loop_command_handshake;
  import tlc_pkg::*;
  logic             clk;
  logic             sys_rst;
  logic             req_valid;
  logic [15:0]      req_cmd;
  logic [15:0]      req_data;
  logic             req_ready;
  logic             done;
  logic             err;
  logic [15:0]      result;
  logic [3:0][15:0] pv_raw;
  logic [3:0][15:0] curr_raw;
  logic [3:0]       ctl_out;
  logic [3:0]       burnout_alarm_out;
  int               failures = 0;
  int               checks = 0;
  int               cycles = 0;

  // Both ends and the checker on one interface
  io_word_if io_word_if_inst (.clk(clk));
  temp_loop_dev #(.LOOPS(4), .TUNE_CYCLES(40)) temp_loop_dev_inst (
    .clk(clk), .sys_rst(sys_rst), .io(io_word_if_inst),
    .pv_raw(pv_raw), .curr_raw(curr_raw), .ctl_out(ctl_out),
    .burnout_alarm_out(burnout_alarm_out));
  temp_loop_host temp_loop_host_inst (
    .clk(clk), .sys_rst(sys_rst), .io(io_word_if_inst),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_data(req_data),
    .req_ready(req_ready), .done(done), .err(err), .result(result));
  temp_loop_command_handshake_props #(.LOOPS(4))
    temp_loop_command_handshake_props_inst (
    .clk(clk), .sys_rst(sys_rst), .out_word(io_word_if_inst.out_word),
    .in_word(io_word_if_inst.in_word));

  // Clock source
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask : chk

  task automatic give_verdict;
    $display("Compares %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // One command and data pair through the host end
  task automatic xfer(input logic [15:0] c, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_data  <= d;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do @(posedge clk); while (done !== 1'b1 && ++n < 60);
    if (n >= 60)
      failures++;
  endtask : xfer

  task automatic t_power;
    @(posedge clk);
    chk(io_word_if_inst.in_word, WORD_ZERO);
    chk({12'h000, ctl_out}, 16'h0000);
    xfer(16'hc791, WORD_ZERO);
    chk(result, 16'h0020);
  endtask : t_power

  task automatic t_items;
    for (int i = 0; i < 7; i++)
    begin
      xfer({CMD_TAG, WR_NONE, i[3:0], 4'h2}, WORD_ZERO);
      chk(result, PARAM_RST[i]);
    end
    xfer(16'hc222, 16'h0100);
    chk(result, 16'h0100);
  endtask : t_items

  task automatic t_errors;
    logic [15:0] bad [5] = '{16'hc901, 16'hcb01, 16'hc7c1, 16'hc700,
                             16'hc705};
    foreach (bad[k])
    begin
      xfer(bad[k], WORD_ZERO);
      chk(result, ERR_SETTING);
      chk({15'h0, err}, 16'h0001);
    end
    xfer(16'hc671, 16'h000a);
    chk(result, 16'h003c);
    pv_raw[0] <= 16'h050c;
    xfer(16'hc791, WORD_ZERO);
    chk(result & 16'h0004, 16'h0004);
    pv_raw[0] <= 16'h0032;
  endtask : t_errors

  task automatic t_alarm;
    xfer(16'hcaa1, ALARM_FORCE);
    chk({15'h0, burnout_alarm_out[0]}, 16'h0001);
    xfer(16'hcaa1, ALARM_OFF);
    chk({15'h0, burnout_alarm_out[0]}, 16'h0000);
    xfer(16'hc001, 16'h0064);
    xfer(16'hccd1, WORD_ZERO);
    repeat (4) @(posedge clk);
    chk({15'h0, ctl_out[0]}, 16'h0001);
    xfer(16'hcaa1, 16'h0064);
    repeat (4) @(posedge clk);
    chk({15'h0, burnout_alarm_out[0]}, 16'h0001);
    curr_raw[0] <= 16'h00c8;
    xfer(16'hc7b1, WORD_ZERO);
    chk(result, 16'h00c8);
    chk({15'h0, burnout_alarm_out[0]}, 16'h0001);
    curr_raw[0] <= CURR_LIMIT;
    xfer(16'hc7b1, WORD_ZERO);
    chk(result, CURR_ERR);
    xfer(16'hcaa1, ALARM_OFF);
    chk({15'h0, burnout_alarm_out[0]}, 16'h0000);
    curr_raw[0] <= 16'h0000;
  endtask : t_alarm

  task automatic t_tune;
    xfer(16'hcce1, WORD_ZERO);
    xfer(16'hc001, 16'h0123);
    chk(result, 16'h0064);
    repeat (80) @(posedge clk);
    xfer(16'hc791, WORD_ZERO);
    chk(result & 16'h0002, 16'h0000);
    xfer(16'hc001, 16'h0123);
    chk(result, 16'h0123);
    xfer(16'hccb1, WORD_ZERO);
    repeat (6) @(posedge clk);
    chk({15'h0, ctl_out[0]}, 16'h0001);
  endtask : t_tune

  // Main sequence
  initial
  begin
    sys_rst   = 1'b1;
    req_valid = 1'b0;
    req_cmd   = 16'h0000;
    req_data  = 16'h0000;
    pv_raw    = {4{16'h0032}};
    curr_raw  = '0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_power();
    t_items();
    t_errors();
    t_alarm();
    t_tune();
    give_verdict();
  end
endmodule : tb_temp_loop_command_handshake
